// ==== rtl/tfs_cfg.svh ====
// register map, reset values and timing counts of the tof sensor core
`ifndef TFS_CFG_SVH
`define TFS_CFG_SVH

`define TFS_REG_READOUT_CFG    8'h3a
`define TFS_REG_ILLUM_SEL      8'h3c
`define TFS_REG_TEMP_HIGH      8'h60
`define TFS_REG_TEMP_LOW       8'h61
`define TFS_REG_COPY_STATUS    8'h7e
`define TFS_REG_CLOCK_ENABLE   8'h80
`define TFS_REG_PLL_FB_DIV     8'h82
`define TFS_REG_MOD_DIV        8'h85
`define TFS_REG_SEQ_DIV        8'h86
`define TFS_REG_REF_DIV        8'h87
`define TFS_REG_VIDEO_DIV      8'h89
`define TFS_REG_PUMP_DIV       8'h8a
`define TFS_REG_DEMOD_DELAY    8'h8b
`define TFS_REG_ILLUM_DRV      8'h90
`define TFS_REG_MODE           8'h92
`define TFS_REG_SHUTTER        8'ha4
`define TFS_REG_DLL_CTRL       8'hae
`define TFS_REG_HOST_VIDEO     8'hcb
`define TFS_REG_VIDEO_POL      8'hcc
`define TFS_REG_TRIM_A         8'hd3
`define TFS_REG_TRIM_B         8'hd5

`define TFS_MODE_FOUR_PHASE    8'h00
`define TFS_MODE_SINGLE_PHASE  8'h04
`define TFS_MODE_GRAYSCALE     8'hc4
`define TFS_CLKEN_EXT_MOD_BIT  6
`define TFS_ILLUM_PREHEAT_BIT  3
`define TFS_DLL_ENABLE_BIT     2
`define TFS_TRIM_A_TEMP_MASK   8'h60
`define TFS_COPY_DONE_BIT      0

`define TFS_CLK_PERIOD_NS      10
`define TFS_HW_LAG_NS          3000
`define TFS_HW_LAG_CYCLES      ((`TFS_HW_LAG_NS + `TFS_CLK_PERIOD_NS - 1) / `TFS_CLK_PERIOD_NS)
`define TFS_COPY_CYCLES        16
`define TFS_INTEG_CYCLES       400
`define TFS_READOUT_CYCLES     800

`endif

// ==== rtl/tfs_pkg.sv ====
// types shared by the tof sensor core
package tfs_pkg;

  typedef enum logic [1:0] {
    TFS_F_IDLE  = 2'h0,
    TFS_F_LAG   = 2'h1,
    TFS_F_INTEG = 2'h3,
    TFS_F_READ  = 2'h2
  } tfs_frame_e;

  typedef enum logic [2:0] {
    TFS_I_IDLE = 3'h0,
    TFS_I_ADDR = 3'h1,
    TFS_I_PTR  = 3'h3,
    TFS_I_WR   = 3'h2,
    TFS_I_RD   = 3'h6
  } tfs_i2c_e;

  typedef struct packed {
    logic [7:0] clock_enable;
    logic       ext_mod_sel;
    logic [7:0] pll_feedback;
    logic [7:0] mod_div;
    logic [7:0] video_div;
    logic       preheat;
    logic       dll_enable;
  } tfs_clk_s;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] demod_delay;
    logic [1:0] phase_index;
    logic       single_phase;
    logic       grayscale;
    logic       reduced_gain;
  } tfs_frame_s;

endpackage : tfs_pkg

// ==== rtl/tfs_sync2.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps

module tfs_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_async,
  input  wire logic [W-1:0] i_reset_val,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] stage1;

  // reset value is a constant at the instance, so no port leaks into reset
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      stage1 <= i_reset_val;
      o_sync <= i_reset_val;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule : tfs_sync2

// ==== rtl/tfs_regmem.sv ====
// 256 x 8 configuration store with registered read data
`timescale 1ns/1ps

module tfs_regmem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_reset,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule : tfs_regmem

// ==== rtl/tfs_core.sv ====
// tof sensor register port, start-up copy, clock config and frame sequencing
`timescale 1ns/1ps
`include "tfs_cfg.svh"

// Behaviour
// - temperature grayscale frame has reduced gain
// - copy-done flag set after reset copy
// - pll feedback, modulation and video divider registers drive clock configuration
// - clock enable bit selects external modulation
// - default four-phase; shutter starts frame
// - mode selects single-phase or grayscale
// - demodulation delay selects phase index
// - register or pin shutter, pin lag
// - mode, delay and trim changes apply from next frame; clock config applies at once
module tfs_core #(
  parameter logic [6:0] DEV_ADDR      = 7'h22,
  parameter logic [7:0] TRIM_A_DEF    = 8'h00,
  parameter logic [7:0] TRIM_B_DEF    = 8'h00,
  parameter int         INTEG_CYCLES  = `TFS_INTEG_CYCLES,
  parameter int         READ_CYCLES   = `TFS_READOUT_CYCLES
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset,
  input  wire logic              i_scl,
  input  wire logic              i_sda,
  output logic                   o_sda_out,
  output logic                   o_sda_oe,
  input  wire logic              i_shutter,
  input  wire logic [15:0]       i_temp_raw,
  output logic                   o_copy_done,
  output logic                   o_integrating,
  output logic                   o_reading,
  output logic                   o_frame_sync,
  output tfs_pkg::tfs_clk_s      o_clk_cfg,
  output tfs_pkg::tfs_frame_s    o_frame_cfg
);

  localparam int LAG_CYCLES = `TFS_HW_LAG_CYCLES;

  function automatic logic [7:0] inc8(input logic [7:0] v);
    inc8 = v + 8'h01;
  endfunction : inc8

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] pins_sync;
  logic       scl;
  logic       sda;
  logic       shut;
  logic       scl_q;
  logic       sda_q;
  logic       shut_q;

  tfs_sync2 #(.W(3)) u_sync (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_async     ({i_scl, i_sda, i_shutter}),
    .i_reset_val (3'h6),
    .o_sync      (pins_sync)
  );

  assign scl  = pins_sync[2];
  assign sda  = pins_sync[1];
  assign shut = pins_sync[0];

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      shut_q <= 1'b0;
    end else begin
      scl_q  <= scl;
      sda_q  <= sda;
      shut_q <= shut;
    end
  end

  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire i2c_start = scl & scl_q & sda_q & ~sda;
  wire i2c_stop  = scl & scl_q & ~sda_q & sda;
  wire hw_shut   = shut & ~shut_q;

  ////////////////////////////////////////////////////////////////////////////
  // start-up copy of factory trims
  logic [4:0] copy_cnt;
  logic       copy_done;
  wire        copy_we    = ~copy_done && (copy_cnt == 5'h01 || copy_cnt == 5'h02);
  wire [7:0]  copy_addr  = (copy_cnt == 5'h01) ? `TFS_REG_TRIM_A : `TFS_REG_TRIM_B;
  wire [7:0]  copy_data  = (copy_cnt == 5'h01) ? TRIM_A_DEF : TRIM_B_DEF;

  // flag rises once trims are back
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      copy_cnt  <= 5'h00;
      copy_done <= 1'b0;
    end else if (!copy_done) begin
      copy_cnt  <= copy_cnt + 5'h01;
      copy_done <= (copy_cnt == 5'(`TFS_COPY_CYCLES - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // i2c slave: address, pointer, auto-incrementing data
  tfs_pkg::tfs_i2c_e i2c_st;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [3:0] bitcnt;
  logic       ack_phase;
  logic [7:0] ptr;
  logic [7:0] mem_rdata;
  logic       i2c_we;

  wire byte_end  = scl_fall && !ack_phase && bitcnt == 4'h8;
  wire addr_hit  = shreg[7:1] == DEV_ADDR;
  // writes during the copy are refused so the trims cannot be clobbered
  wire wr_accept = (i2c_st == tfs_pkg::TFS_I_WR) && byte_end && copy_done;
  assign i2c_we  = wr_accept;

  logic [7:0] temp_high;
  logic [7:0] temp_low;
  wire [7:0]  rd_byte = (ptr == `TFS_REG_TEMP_HIGH)   ? temp_high :
                        (ptr == `TFS_REG_TEMP_LOW)    ? temp_low  :
                        (ptr == `TFS_REG_COPY_STATUS) ? {7'h00, copy_done} :
                        mem_rdata;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset || i2c_start || i2c_stop) begin
      i2c_st    <= (i2c_start && !i_reset) ? tfs_pkg::TFS_I_ADDR : tfs_pkg::TFS_I_IDLE;
      bitcnt    <= 4'h0;
      ack_phase <= 1'b0;
      o_sda_oe  <= 1'b0;
    end else if (i2c_st != tfs_pkg::TFS_I_IDLE) begin
      if (scl_rise && !ack_phase) begin
        shreg  <= {shreg[6:0], sda};
        bitcnt <= bitcnt + 4'h1;
      end
      // master nack ends a read
      if (scl_rise && ack_phase && i2c_st == tfs_pkg::TFS_I_RD && sda) begin
        i2c_st <= tfs_pkg::TFS_I_IDLE;
      end
      if (scl_fall && ack_phase) begin
        ack_phase <= 1'b0;
        bitcnt    <= 4'h0;
        o_sda_oe  <= (i2c_st == tfs_pkg::TFS_I_RD) ? ~rd_byte[7] : 1'b0;
        txreg     <= rd_byte;
      end else if (byte_end) begin
        ack_phase <= 1'b1;
        unique case (i2c_st)
          tfs_pkg::TFS_I_ADDR: begin
            o_sda_oe <= addr_hit;
            i2c_st   <= !addr_hit ? tfs_pkg::TFS_I_IDLE :
                        shreg[0] ? tfs_pkg::TFS_I_RD : tfs_pkg::TFS_I_PTR;
          end
          tfs_pkg::TFS_I_PTR: begin
            o_sda_oe <= 1'b1;
            ptr      <= shreg;
            i2c_st   <= tfs_pkg::TFS_I_WR;
          end
          tfs_pkg::TFS_I_WR: begin
            o_sda_oe <= copy_done;
            if (copy_done) begin
              ptr <= inc8(ptr);
            end
          end
          tfs_pkg::TFS_I_RD: begin
            o_sda_oe <= 1'b0;
            ptr      <= inc8(ptr);
          end
          default: begin
            o_sda_oe <= 1'b0;
          end
        endcase
      end else if (scl_fall && i2c_st == tfs_pkg::TFS_I_RD && bitcnt != 4'h0) begin
        txreg    <= {txreg[6:0], 1'b0};
        o_sda_oe <= ~txreg[6];
      end
    end
  end

  assign o_sda_out = 1'b0;

  tfs_regmem #(.AW(8), .DW(8)) u_regs (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_we      (i2c_we | copy_we),
    .i_waddr   (copy_we ? copy_addr : ptr),
    .i_wdata   (copy_we ? copy_data : shreg),
    .i_raddr   (ptr),
    .o_rdata   (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shadow copies of the registers that steer the core
  logic [7:0] sh_mode;
  logic [7:0] sh_delay;
  logic [7:0] sh_trim_a;
  wire  [7:0] wr_addr = copy_we ? copy_addr : ptr;
  wire  [7:0] wr_data = copy_we ? copy_data : shreg;
  wire        wr_any  = i2c_we | copy_we;
  wire        sw_shut = i2c_we && ptr == `TFS_REG_SHUTTER;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sh_mode   <= `TFS_MODE_FOUR_PHASE;
      sh_delay  <= 8'h00;
      sh_trim_a <= 8'h00;
      o_clk_cfg <= '0;
    end else if (wr_any) begin
      // pll feedback, modulation and video divider values go straight to the clock tree
      unique case (wr_addr)
        `TFS_REG_MODE:         sh_mode   <= wr_data;
        `TFS_REG_DEMOD_DELAY:  sh_delay  <= wr_data;
        `TFS_REG_TRIM_A:       sh_trim_a <= wr_data;
        `TFS_REG_PLL_FB_DIV:   o_clk_cfg.pll_feedback <= wr_data;
        `TFS_REG_MOD_DIV:      o_clk_cfg.mod_div      <= wr_data;
        `TFS_REG_VIDEO_DIV:    o_clk_cfg.video_div    <= wr_data;
        `TFS_REG_ILLUM_DRV:    o_clk_cfg.preheat      <= wr_data[`TFS_ILLUM_PREHEAT_BIT];
        `TFS_REG_DLL_CTRL:     o_clk_cfg.dll_enable   <= wr_data[`TFS_DLL_ENABLE_BIT];
        // bit 6 routes the external modulation input
        `TFS_REG_CLOCK_ENABLE: begin
          o_clk_cfg.clock_enable <= wr_data;
          o_clk_cfg.ext_mod_sel  <= wr_data[`TFS_CLKEN_EXT_MOD_BIT];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer
  tfs_pkg::tfs_frame_e frame_st;
  logic [15:0] fcnt;
  wire         idle    = frame_st == tfs_pkg::TFS_F_IDLE;
  wire         cnt_end = fcnt == 16'h0000;

  // shadows are sampled only when a frame begins
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_frame_cfg <= '0;
    end else if (idle && (sw_shut || hw_shut)) begin
      o_frame_cfg.mode         <= sh_mode;
      o_frame_cfg.demod_delay  <= sh_delay;
      o_frame_cfg.phase_index  <= sh_delay[2:1];
      // mode code picks the acquisition kind
      o_frame_cfg.single_phase <= sh_mode == `TFS_MODE_SINGLE_PHASE;
      o_frame_cfg.grayscale    <= sh_mode == `TFS_MODE_GRAYSCALE;
      // temperature trims cut gain by 2.5
      o_frame_cfg.reduced_gain <= sh_mode == `TFS_MODE_GRAYSCALE &&
                                  (sh_trim_a & `TFS_TRIM_A_TEMP_MASK) == `TFS_TRIM_A_TEMP_MASK;
    end
  end

  // pin shutter waits the lag, register shutter starts at once
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      frame_st     <= tfs_pkg::TFS_F_IDLE;
      fcnt         <= 16'h0000;
      o_frame_sync <= 1'b0;
    end else begin
      unique case (frame_st)
        tfs_pkg::TFS_F_IDLE: begin
          if (sw_shut) begin
            frame_st     <= tfs_pkg::TFS_F_INTEG;
            fcnt         <= 16'(INTEG_CYCLES - 1);
            o_frame_sync <= 1'b0;
          end else if (hw_shut) begin
            frame_st     <= tfs_pkg::TFS_F_LAG;
            fcnt         <= 16'(LAG_CYCLES - 1);
            o_frame_sync <= 1'b0;
          end
        end
        tfs_pkg::TFS_F_LAG: begin
          fcnt <= cnt_end ? 16'(INTEG_CYCLES - 1) : fcnt - 16'h0001;
          if (cnt_end) begin
            frame_st <= tfs_pkg::TFS_F_INTEG;
          end
        end
        tfs_pkg::TFS_F_INTEG: begin
          fcnt <= cnt_end ? 16'(READ_CYCLES - 1) : fcnt - 16'h0001;
          if (cnt_end) begin
            frame_st <= tfs_pkg::TFS_F_READ;
          end
        end
        tfs_pkg::TFS_F_READ: begin
          fcnt <= fcnt - 16'h0001;
          if (cnt_end) begin
            frame_st     <= tfs_pkg::TFS_F_IDLE;
            o_frame_sync <= 1'b1;
          end
        end
      endcase
    end
  end

  // temperature bytes land together with the end of a reduced-gain grayscale transfer
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      temp_high <= 8'h00;
      temp_low  <= 8'h00;
    end else if (frame_st == tfs_pkg::TFS_F_READ && cnt_end && o_frame_cfg.reduced_gain) begin
      temp_high <= i_temp_raw[15:8];
      temp_low  <= i_temp_raw[7:0];
    end
  end

  assign o_copy_done   = copy_done;
  assign o_integrating = frame_st == tfs_pkg::TFS_F_INTEG;
  assign o_reading     = frame_st == tfs_pkg::TFS_F_READ;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_copy_flag_time: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $rose(copy_done) |-> copy_cnt == 5'(`TFS_COPY_CYCLES))
    else $error("copy flag rose at wrong time");
  a_hw_lag_len: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (idle && hw_shut && !sw_shut) |=> frame_st == tfs_pkg::TFS_F_LAG [*8])
    else $error("hw shutter lag too short");
  a_sw_shut_start: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (idle && sw_shut) |=> o_integrating)
    else $error("sw shutter did not start integration");
  a_cfg_hold_frame: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (!idle && !$past(idle)) |-> $stable(o_frame_cfg))
    else $error("frame config changed mid frame");
  a_mode_gray_dec: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (idle && sw_shut && sh_mode == `TFS_MODE_GRAYSCALE) |=> o_frame_cfg.grayscale
    && !o_frame_cfg.single_phase)
    else $error("grayscale mode not decoded");
  a_phase_index_map: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (idle && (sw_shut || hw_shut) && sh_delay == 8'h06) |=> o_frame_cfg.phase_index == 2'h3)
    else $error("phase index mismatch");
  a_ext_mod_sel: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_clk_cfg.ext_mod_sel == o_clk_cfg.clock_enable[`TFS_CLKEN_EXT_MOD_BIT])
    else $error("external modulation select wrong");
  a_mod_div_write: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i2c_we && ptr == `TFS_REG_MOD_DIV) |=> o_clk_cfg.mod_div == $past(shreg))
    else $error("modulation divider not taken");
  a_reduced_gain: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_frame_cfg.reduced_gain |-> o_frame_cfg.grayscale)
    else $error("reduced gain outside grayscale");
  a_sync_frame_end: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $rose(o_frame_sync) |-> $past(o_reading) && idle)
    else $error("frame sync without readout");
  c_hw_frame: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    frame_st == tfs_pkg::TFS_F_LAG ##1 frame_st == tfs_pkg::TFS_F_LAG);
  c_temp_frame: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    o_frame_cfg.reduced_gain && $rose(o_frame_sync));
  c_i2c_read: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    i2c_st == tfs_pkg::TFS_I_RD && byte_end);

endmodule : tfs_core

// ==== verification/tfs_host_model.sv ====
// host controller model: i2c master on an open-drain data line plus the shutter pin
`timescale 1ns/1ps

module tfs_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h22
) (
  input  wire logic i_ref_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe,
  output logic      o_shutter
);

  initial begin
    o_scl     = 1'b1;
    o_sda_oe  = 1'b0;
    o_shutter = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : step

  ////////////////////////////////////////////////////////////////////////////////
  // scl high for 8 clocks and low for 9; data moves one clock after scl falls, never while high
  task automatic bit_io(input logic b, output logic s);
    o_sda_oe <= ~b;
    step(8);
    o_scl <= 1'b1;
    step(8);
    s = i_sda;
    o_scl <= 1'b0;
    step(1);
  endtask : bit_io

  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    // ninth bit released; a read always ends with a master nack
    bit_io(1'b1, s);
    ack = ~s;
  endtask : byte_io

  task automatic start_cond();
    o_sda_oe <= 1'b0;
    step(4);
    o_scl <= 1'b1;
    step(8);
    o_sda_oe <= 1'b1;
    step(8);
    o_scl <= 1'b0;
    step(1);
  endtask : start_cond

  task automatic stop_cond();
    o_sda_oe <= 1'b1;
    step(8);
    o_scl <= 1'b1;
    step(8);
    o_sda_oe <= 1'b0;
    step(8);
  endtask : stop_cond

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ack);
    logic [7:0] q;
    logic       k;
    start_cond();
    byte_io({DEV_ADDR, 1'b0}, q, k);
    byte_io(a, q, k);
    byte_io(d, q, ack);
    stop_cond();
  endtask : wr

  // pointer set by a data-less write, then repeated start and one byte read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic       k;
    start_cond();
    byte_io({DEV_ADDR, 1'b0}, q, k);
    byte_io(a, q, k);
    start_cond();
    byte_io({DEV_ADDR, 1'b1}, q, k);
    byte_io(8'hff, d, k);
    stop_cond();
  endtask : rd

  task automatic probe(input logic [6:0] dev, output logic ack);
    logic [7:0] q;
    start_cond();
    byte_io({dev, 1'b0}, q, ack);
    stop_cond();
  endtask : probe

  // tenths of a degree: code offset, 0.134 per step, cal byte / 4.7 - 299
  function automatic int temp_tenths(input logic [7:0] hi_byte, input logic [7:0] lo_byte,
                                     input logic [7:0] cal);
    temp_tenths = ((int'({hi_byte, lo_byte}) - 32'sh2000) * 32'sh86) / 32'sh64
                  + (int'(cal) * 32'sh64) / 32'sh2f - 32'sh12b * 32'sh0a;
  endfunction : temp_tenths

  // recursive filter, quarter weight on the new reading keeps noise out
  function automatic int temp_filter(input int y, input int x);
    temp_filter = y + (x - y) / 32'sh4;
  endfunction : temp_filter

  task automatic shutter(input logic v);
    o_shutter <= v;
  endtask : shutter

endmodule : tfs_host_model

// ==== verification/tfs_core_test.sv ====
// self-checking bench for the tof sensor core: start-up, clock set-up and frames
`timescale 1ns/1ps

module tfs_core_test;
  localparam logic [6:0] DEV   = 7'h22;
  localparam int         INTEG = 400;
  localparam int         READ  = 800;
  localparam logic [7:0] CA [14] = '{8'h3a, 8'h3c, 8'h90, 8'hae, 8'h80, 8'h82, 8'h85,
                                     8'h86, 8'h87, 8'h89, 8'h8a, 8'h80, 8'h80, 8'h10};
  localparam logic [7:0] CD [14] = '{8'h30, 8'h26, 8'h08, 8'h04, 8'h00, 8'h09, 8'h00,
                                     8'h04, 8'h00, 8'h01, 8'h01, 8'h3f, 8'h7f, 8'h5a};

  logic                clk         = 1'b0;
  logic                rst         = 1'b1;
  logic [15:0]         temp_raw    = 16'h2a5c;
  logic                scl;
  logic                host_oe;
  logic                shutter;
  logic                dut_oe;
  logic                dut_out;
  logic                copy_done;
  logic                integ;
  logic                reading;
  logic                fsync;
  tfs_pkg::tfs_clk_s   clk_cfg;
  tfs_pkg::tfs_frame_s frame_cfg;
  wire logic           sda         = host_oe ? 1'b0 : (dut_oe ? dut_out : 1'b1);
  int                  bad_count   = 0;
  int                  checks_done = 0;
  int                  n_int       = 0;
  int                  n_rd        = 0;
  int                  n_int0      = 0;
  int                  n_rd0       = 0;
  logic [7:0]          q;
  logic                ack;

  always #5 clk = ~clk;

  tfs_core #(.DEV_ADDR(DEV), .INTEG_CYCLES(INTEG), .READ_CYCLES(READ)) dut_u (
    .i_ref_clk(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(dut_out),
    .o_sda_oe(dut_oe), .i_shutter(shutter), .i_temp_raw(temp_raw),
    .o_copy_done(copy_done), .o_integrating(integ), .o_reading(reading),
    .o_frame_sync(fsync), .o_clk_cfg(clk_cfg), .o_frame_cfg(frame_cfg)
  );

  tfs_host_model #(.DEV_ADDR(DEV)) host_u (
    .i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe), .o_shutter(shutter)
  );

  // frame phase lengths, never cleared; the bench snapshots them before each trigger
  always @(posedge clk) begin
    if (integ === 1'b1) n_int <= n_int + 1;
    if (reading === 1'b1) n_rd <= n_rd + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t value mismatch: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.wr(a, d, ack);
    check(ack, 1'b1);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, q);
    check(q, exp);
  endtask : rdchk

  task automatic fire();
    n_int0 = n_int;
    n_rd0  = n_rd;
    wr(8'ha4, 8'h01);
  endtask : fire

  task automatic end_frame(input string name);
    int t;
    t = 0;
    while (fsync !== 1'b1 && t < 3000) begin
      @(posedge clk);
      t++;
    end
    @(posedge clk);
    check(t < 3000, 1'b1);
    check(64'(n_int - n_int0), 64'(INTEG));
    check(64'(n_rd - n_rd0), 64'(READ));
    $display("test %s done", name);
  endtask : end_frame

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int         t;
    logic [7:0] sv_a;
    logic [7:0] sv_b;
    logic [7:0] t_hi;
    repeat (4) @(posedge clk);
    check(copy_done, 1'b0);
    check({fsync, clk_cfg, frame_cfg}, '0);
    rst <= 1'b0;
    t = 0;
    while (copy_done !== 1'b1 && t < 100) begin
      @(posedge clk);
      t++;
    end
    check(64'(t), 64'd17);
    rdchk(8'h7e, 8'h01);
    host_u.wr(8'h7e, 8'hff, ack);
    rdchk(8'h7e, 8'h01);
    host_u.probe(7'h23, ack);
    check(ack, 1'b0);
    host_u.probe(DEV, ack);
    check(ack, 1'b1);
    $display("test start-up done");
    // start-up writes, clocks gated around dividers
    for (int i = 0; i < 14; i++) begin
      wr(CA[i], CD[i]);
      if (CA[i] == 8'h80) begin
        check(clk_cfg.clock_enable, CD[i]);
        check(clk_cfg.ext_mod_sel, CD[i][6]);
      end
    end
    check({clk_cfg.pll_feedback, clk_cfg.mod_div, clk_cfg.video_div}, 24'h090001);
    check({clk_cfg.preheat, clk_cfg.dll_enable}, 2'b11);
    for (int i = 0; i < 14; i++) begin
      if (CA[i] != 8'h80) rdchk(CA[i], CD[i]);
    end
    $display("test clocks done");
    fire();
    check({frame_cfg.mode, frame_cfg.single_phase, frame_cfg.grayscale}, 10'h000);
    end_frame("default mode");
    wr(8'h92, 8'h04);
    for (int p = 0; p < 4; p++) begin
      wr(8'h8b, 8'(2 * p));
      fire();
      check({frame_cfg.demod_delay, frame_cfg.phase_index}, {8'(2 * p), 2'(p)});
      check(frame_cfg.single_phase, 1'b1);
      end_frame("phase");
    end
    fire();
    wr(8'h92, 8'hc4);
    check(frame_cfg.mode, 8'h04);
    end_frame("late write");
    fire();
    check({frame_cfg.grayscale, frame_cfg.reduced_gain}, 2'b10);
    end_frame("grayscale");
    host_u.rd(8'hd3, sv_a);
    host_u.rd(8'hd5, sv_b);
    check({sv_a, sv_b}, 16'h0000);
    wr(8'hd3, sv_a | 8'h60);
    wr(8'hd5, sv_b & 8'h0f);
    temp_raw <= 16'h21c7;
    fire();
    check({frame_cfg.grayscale, frame_cfg.reduced_gain}, 2'b11);
    end_frame("temperature");
    rdchk(8'h60, 8'h21);
    t_hi = q;
    rdchk(8'h61, 8'hc7);
    check(64'(host_u.temp_tenths(t_hi, q, 8'h00)), 64'(-32'sh94d));
    check(64'(host_u.temp_filter(32'sh0, 32'sh64)), 64'h19);
    wr(8'hd3, sv_a);
    wr(8'hd5, sv_b);
    wr(8'h92, 8'h04);
    rdchk(8'hd3, 8'h00);
    n_int0 = n_int;
    n_rd0  = n_rd;
    host_u.shutter(1'b1);
    t = 0;
    while (integ !== 1'b1 && t < 400) begin
      @(posedge clk);
      t++;
    end
    host_u.shutter(1'b0);
    check(t >= 300 && t <= 306, 1'b1);
    check(frame_cfg.single_phase, 1'b1);
    wr(8'ha4, 8'h01);
    end_frame("pin shutter");
    give_verdict();
  end

  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

endmodule : tfs_core_test
